// file: core/rspt_top.v
`timescale 1ns/1ns
`default_nettype none
`include "rspt_consts.vh"
module rspt_top #(
    parameter BIT_CYCLES = `RSPT_BIT_CYCLES
) (
    // Clock and reset
    input  wire                      sys_clk,
    input  wire                      srst,
    // Trigger pin from host
    input  wire                      trigIn,
    // Samples from the sensing core
    input  wire [`RSPT_RATE_W-1:0]   rateSample,
    input  wire [`RSPT_TEMP_W-1:0]   tempSample,
    // Serial output and status flags
    output reg                       txData,
    output reg                       txBusy,
    output reg                       pktOverrun
);
    reg        trigMeta_ff;
    reg        trigSync_ff;
    reg        trigPrev_ff;
    reg [3:0]  byteIdx_ff;
    reg        loading_ff;
    reg [31:0] rate_ff;
    reg [13:0] temp_ff;
    reg [6:0]  rateChk_ff;
    reg [6:0]  allChk_ff;
    reg [7:0]  curByte;
    wire       trigFall;
    wire       fifoInReady;
    wire       fifoOutValid;
    wire       txReady;
    wire       lineBit;
    wire       lineBusy;
    wire [7:0] fifoOutData;

    // Byte of the packet at a given index
    function [7:0] pktByte;
        input [3:0]  idx;
        input [31:0] r;
        input [13:0] t;
        input [6:0]  rc;
        input [6:0]  ac;
        begin
            case (idx)
                4'd0:    pktByte = `RSPT_HEADER;
                4'd1:    pktByte = {1'b0, r[6:0]};
                4'd2:    pktByte = {1'b0, r[13:7]};
                4'd3:    pktByte = {1'b0, r[20:14]};
                4'd4:    pktByte = {1'b0, r[27:21]};
                4'd5:    pktByte = {4'h0, r[31:28]};
                4'd6:    pktByte = {1'b0, rc};
                4'd7:    pktByte = {1'b0, t[6:0]};
                4'd8:    pktByte = {1'b0, t[13:7]};
                4'd9:    pktByte = {1'b0, ac};
                default: pktByte = 8'h00;
            endcase
        end
    endfunction

    // Two-stage sync, edge seen only past the second stage
    always @(posedge sys_clk) begin
        if (srst) begin
            trigMeta_ff <= 1'b1;
            trigSync_ff <= 1'b1;
            trigPrev_ff <= 1'b1;
        end else begin
            trigMeta_ff <= trigIn;
            trigSync_ff <= trigMeta_ff;
            trigPrev_ff <= trigSync_ff;
        end
    end
    assign trigFall = trigPrev_ff & ~trigSync_ff;

    // Current byte with bit seven clear on all payload bytes
    always @* begin
        curByte = pktByte(byteIdx_ff, rate_ff, temp_ff, rateChk_ff,
                          allChk_ff);
    end

    // Packet builder: latch samples, push ten bytes into the FIFO
    always @(posedge sys_clk) begin
        if (srst) begin
            byteIdx_ff <= 4'h0;
            loading_ff <= 1'b0;
            rate_ff    <= 32'h0000_0000;
            temp_ff    <= 14'h0000;
            rateChk_ff <= 7'h00;
            allChk_ff  <= 7'h00;
            pktOverrun <= 1'b0;
        end else begin
            if (trigFall && !loading_ff) begin
                // Signed samples latched raw, sign is top bit
                rate_ff    <= rateSample;
                temp_ff    <= tempSample;
                byteIdx_ff <= 4'h0;
                loading_ff <= 1'b1;
                rateChk_ff <= 7'h00;
                allChk_ff  <= 7'h00;
                // Host trigger faster than the line is flagged; the bytes wait in the FIFO
                pktOverrun <= fifoOutValid | lineBusy;
            end else if (loading_ff && fifoInReady) begin
                // Check bytes cover payload only, header excluded
                if (byteIdx_ff >= 4'd1 && byteIdx_ff <= 4'd5) begin
                    rateChk_ff <= rateChk_ff ^ curByte[6:0];
                end
                if (byteIdx_ff >= 4'd1 && byteIdx_ff <= 4'd8) begin
                    allChk_ff <= allChk_ff ^ curByte[6:0];
                end
                if (byteIdx_ff == `RSPT_PKT_BYTES - 1) begin
                    loading_ff <= 1'b0;
                end else begin
                    byteIdx_ff <= byteIdx_ff + 4'h1;
                end
            end
        end
    end

    // Sixteen-byte buffer decouples packet build from line rate
    rspt_fifo #(
        .WIDTH (8),
        .DEPTH (`RSPT_FIFO_DEPTH),
        .AW    (4)
    ) uFifo (
        .sys_clk  (sys_clk),
        .srst     (srst),
        .inValid  (loading_ff),
        .inReady  (fifoInReady),
        .inData   (curByte),
        .outValid (fifoOutValid),
        .outReady (txReady),
        .outData  (fifoOutData)
    );

    // Character serialiser
    rspt_uart_tx #(
        .BIT_CYCLES (BIT_CYCLES)
    ) uTx (
        .sys_clk   (sys_clk),
        .srst      (srst),
        .byteValid (fifoOutValid),
        .byteReady (txReady),
        .byteData  (fifoOutData),
        .txLine    (lineBit),
        .txBusy    (lineBusy)
    );

    // Outputs retimed so each comes straight from a flop
    always @(posedge sys_clk) begin
        if (srst) begin
            txData <= `RSPT_IDLE_LEVEL;
            txBusy <= 1'b0;
        end else begin
            txData <= lineBit;
            txBusy <= lineBusy | fifoOutValid | loading_ff;
        end
    end
endmodule
`default_nettype wire

// file: core/rspt_consts.vh
`ifndef RSPT_CONSTS_VH
`define RSPT_CONSTS_VH

`define RSPT_CLK_HZ        100000000
`define RSPT_BAUD_X10      4608000
`define RSPT_BIT_CYCLES    ((`RSPT_CLK_HZ * 10) / `RSPT_BAUD_X10)
`define RSPT_CHAR_BITS     11
`define RSPT_PKT_BYTES     10
`define RSPT_HEADER        8'h80
`define RSPT_RATE_W        32
`define RSPT_TEMP_W        14
`define RSPT_FIFO_DEPTH    16
`define RSPT_IDLE_LEVEL    1'b1

`endif

// file: core/rspt_fifo.v
`timescale 1ns/1ns
`default_nettype none
module rspt_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    // Clock and reset
    input  wire             sys_clk,
    input  wire             srst,
    // Fill side
    input  wire             inValid,
    output wire             inReady,
    input  wire [WIDTH-1:0] inData,
    // Drain side
    output wire             outValid,
    input  wire             outReady,
    output wire [WIDTH-1:0] outData
);
    reg [WIDTH-1:0] memFf [0:DEPTH-1];
    reg [AW-1:0]    wrPtr_ff;
    reg [AW-1:0]    rdPtr_ff;
    reg [AW:0]      count_ff;
    wire            doWrite;
    wire            doRead;

    // Full and empty from the occupancy count
    assign inReady  = (count_ff != DEPTH[AW:0]);
    assign outValid = (count_ff != {(AW+1){1'b0}});
    assign outData  = memFf[rdPtr_ff];
    assign doWrite  = inValid & inReady;
    assign doRead   = outValid & outReady;

    // Storage write, no reset needed on data
    always @(posedge sys_clk) begin
        if (doWrite) begin
            memFf[wrPtr_ff] <= inData;
        end
    end

    // Pointers wrap at DEPTH, which should be a power of two
    always @(posedge sys_clk) begin
        if (srst) begin
            wrPtr_ff <= {AW{1'b0}};
            rdPtr_ff <= {AW{1'b0}};
            count_ff <= {(AW+1){1'b0}};
        end else begin
            if (doWrite) begin
                wrPtr_ff <= wrPtr_ff + 1'b1;
            end
            if (doRead) begin
                rdPtr_ff <= rdPtr_ff + 1'b1;
            end
            if (doWrite & ~doRead) begin
                count_ff <= count_ff + 1'b1;
            end else if (doRead & ~doWrite) begin
                count_ff <= count_ff - 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// file: core/rspt_uart_tx.v
`timescale 1ns/1ns
`default_nettype none
`include "rspt_consts.vh"
module rspt_uart_tx #(
    parameter BIT_CYCLES = `RSPT_BIT_CYCLES
) (
    // Clock and reset
    input  wire       sys_clk,
    input  wire       srst,
    // Byte stream in
    input  wire       byteValid,
    output reg        byteReady,
    input  wire [7:0] byteData,
    // Serial line
    output reg        txLine,
    output reg        txBusy
);
    reg [10:0] shift_ff;
    reg [3:0]  bitCnt_ff;
    reg [15:0] baudCnt_ff;

    // Shift register timed by a bit-period divider
    always @(posedge sys_clk) begin
        if (srst) begin
            shift_ff   <= {11{1'b1}};
            bitCnt_ff  <= 4'h0;
            baudCnt_ff <= 16'h0000;
            txLine     <= `RSPT_IDLE_LEVEL;
            txBusy     <= 1'b0;
            byteReady  <= 1'b0;
        end else if (!txBusy) begin
            txLine <= `RSPT_IDLE_LEVEL;
            byteReady <= 1'b0;
            if (byteValid && !byteReady) begin
                // Stop, even parity, data LSB first, start
                shift_ff <= {1'b1, ^byteData, byteData, 1'b0};
                bitCnt_ff  <= 4'h0;
                baudCnt_ff <= 16'h0000;
                txBusy     <= 1'b1;
                byteReady  <= 1'b1;
            end
        end else begin
            byteReady <= 1'b0;
            txLine    <= shift_ff[0];
            if (baudCnt_ff == BIT_CYCLES - 1) begin
                baudCnt_ff <= 16'h0000;
                shift_ff   <= {1'b1, shift_ff[10:1]};
                if (bitCnt_ff == `RSPT_CHAR_BITS - 1) begin
                    txBusy <= 1'b0;
                end else begin
                    bitCnt_ff <= bitCnt_ff + 4'h1;
                end
            end else begin
                baudCnt_ff <= baudCnt_ff + 16'h0001;
            end
        end
    end
endmodule
`default_nettype wire

// file: verification/rspt_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module rspt_host_model #(
    parameter int BIT_CYCLES = 4
) (
    // Clock and line
    input  wire logic        sys_clk,
    input  wire logic        txData,
    // Received bytes and counts
    output var  logic [79:0] rxPkt,
    output var  logic [15:0] rxChars,
    output var  logic [15:0] rxBad
);
    logic [9:0] bits;

    initial begin
        rxPkt = '0;
        rxChars = '0;
        rxBad = '0;
    end

    // Sample mid-bit so line edges never race the read
    always begin
        @(negedge txData);
        repeat (BIT_CYCLES / 2) @(posedge sys_clk);
        for (int i = 0; i < 10; i++) begin
            repeat (BIT_CYCLES) @(posedge sys_clk);
            bits[i] = txData;
        end
        if (^bits[8:0] || !bits[9]) rxBad = rxBad + 1;
        rxPkt = {rxPkt[71:0], bits[7:0]};
        rxChars = rxChars + 1;
    end
endmodule
`default_nettype wire

// file: verification/rspt_checker.sv
`timescale 1ns/1ns
`default_nettype none
module rspt_checker #(
    parameter int BIT_CYCLES = 217
) (
    // Clock and reset
    input wire logic        sys_clk,
    input wire logic        srst,
    // Inputs
    input wire logic        trigIn,
    input wire logic [31:0] rateSample,
    input wire logic [13:0] tempSample,
    // Outputs
    input wire logic        txData,
    input wire logic        txBusy,
    input wire logic        pktOverrun
);
    localparam int PKT_MAX = 250 * BIT_CYCLES + 100;
    logic [31:0] lowRun_ff;
    logic [31:0] busyRun_ff;
    logic [7:0]  sinceFall_ff;

    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);

    // Low-run, busy-run and trigger age; age saturates
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            lowRun_ff <= '0;
            busyRun_ff <= '0;
            // A pin already low at release counts as a fresh fall
            sinceFall_ff <= trigIn ? 8'hFF : 8'h00;
        end else begin
            lowRun_ff <= txData ? '0 : lowRun_ff + 1;
            busyRun_ff <= txBusy ? busyRun_ff + 1 : '0;
            if ($fell(trigIn)) sinceFall_ff <= 8'h00;
            else if (sinceFall_ff != 8'hFF) sinceFall_ff <= sinceFall_ff + 1;
        end
    end

    idle_line_a: assert property (!txBusy |-> txData)
        else $error("line low while idle");
    reset_quiet_a: assert property ($fell(srst) |->
        txData && !txBusy && !pktOverrun) else $error("bad reset state");
    start_fall_a: assert property ($fell(trigIn) && !txBusy |->
        ##[3:12] !txData) else $error("no start bit after trigger");
    busy_cause_a: assert property ($rose(txBusy) |->
        sinceFall_ff <= 12) else $error("busy without trigger");
    bit_period_a: assert property ($rose(txData) |->
        lowRun_ff % BIT_CYCLES == 0) else $error("bit width wrong");
    zero_run_a: assert property (lowRun_ff <= 10 * BIT_CYCLES)
        else $error("line low too long");
    pkt_bound_a: assert property (busyRun_ff <= PKT_MAX)
        else $error("packet too long");
    pkt_min_a: assert property ($rose(txBusy) |-> txBusy[*8])
        else $error("packet too short");
endmodule

bind rspt_top rspt_checker #(.BIT_CYCLES(BIT_CYCLES)) i_chk (
    .sys_clk(sys_clk), .srst(srst), .trigIn(trigIn),
    .rateSample(rateSample), .tempSample(tempSample),
    .txData(txData), .txBusy(txBusy), .pktOverrun(pktOverrun)
);
`default_nettype wire

// file: verification/test_rate_sensor_packet_transmitter.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, s) begin n_compared++; if ((e) !== (s)) begin \
    mismatches++; $display("CHECK FAILED %s exp %0h got %0h", nm, e, s); \
    end end
module test_rate_sensor_packet_transmitter;
    // Stimulus, outputs, counters
    logic        sys_clk = 1'b0;
    logic        srst = 1'b1;
    logic        trigIn = 1'b1;
    logic [31:0] rateSample = 32'h0000_0000;
    logic [13:0] tempSample = 14'h0000;
    wire  logic  txData, txBusy, pktOverrun;
    wire  logic [79:0] rxPkt;
    wire  logic [15:0] rxChars, rxBad;
    int          mismatches = 0;
    int          n_compared = 0;

    always #5 sys_clk = ~sys_clk;

    rspt_top #(.BIT_CYCLES(4)) i_dut (.sys_clk(sys_clk), .srst(srst),
        .trigIn(trigIn), .rateSample(rateSample), .tempSample(tempSample),
        .txData(txData), .txBusy(txBusy), .pktOverrun(pktOverrun));
    rspt_host_model #(.BIT_CYCLES(4)) i_host (.sys_clk(sys_clk),
        .txData(txData), .rxPkt(rxPkt), .rxChars(rxChars), .rxBad(rxBad));

    // Last check byte also covers byte six, so the rate groups cancel
    function automatic logic [79:0] expPkt(input logic [31:0] r,
                                           input logic [13:0] t);
        logic [7:0] c6;
        c6 = {1'b0, r[6:0] ^ r[13:7] ^ r[20:14] ^ r[27:21] ^ r[31:28]};
        return {8'h80, 1'b0, r[6:0], 1'b0, r[13:7], 1'b0, r[20:14],
            1'b0, r[27:21], 4'h0, r[31:28], c6, 1'b0, t[6:0], 1'b0,
            t[13:7], 1'b0, t[6:0] ^ t[13:7]};
    endfunction

    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic print_verdict;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // Host trigger: a falling edge, low 20 cycles, back high for 10
    task automatic fire(input logic [31:0] r, input logic [13:0] t);
        rateSample = r;
        tempSample = t;
        trigIn = 1'b0;
        step(20);
        trigIn = 1'b1;
        step(10);
    endtask

    // Bounded wait for n characters and an idle line
    task automatic waitChars(input int n);
        int k;
        k = 0;
        while (rxChars != n[15:0] || txBusy !== 1'b0) begin
            step(1);
            k++;
            if (k == 5000) begin
                mismatches++;
                print_verdict();
            end
        end
        `CHK("idle", 1'b1, txData)
    endtask

    // Contents over sign and boundary values
    task automatic t_content;
        logic [45:0] tb [4];
        logic [79:0] e;
        int c;
        tb = '{{32'h8765_4321, 14'h2ABC}, {32'h0000_0000, 14'h0000},
            {32'hFFFF_FFFF, 14'h3FFF}, {32'h7FFF_FFFF, 14'h1FFF}};
        for (int i = 0; i < 4; i++) begin
            c = rxChars;
            e = expPkt(tb[i][45:14], tb[i][13:0]);
            fire(tb[i][45:14], tb[i][13:0]);
            waitChars(c + 10);
            `CHK("head", e[79:72], rxPkt[79:72])
            `CHK("rate", e[71:24], rxPkt[71:24])
            `CHK("temp", e[23:0], rxPkt[23:0])
            `CHK("parity", 16'h0000, rxBad)
            `CHK("overrun", 1'b0, pktOverrun)
        end
    endtask

    // Trigger while sending: packet queues, overrun flagged
    task automatic t_overrun;
        int c;
        c = rxChars;
        fire(32'h1234_5678, 14'h0155);
        fire(32'h8000_0001, 14'h2001);
        waitChars(c + 20);
        `CHK("ovr set", 1'b1, pktOverrun)
        `CHK("second", expPkt(32'h8000_0001, 14'h2001), rxPkt)
        fire(32'h0000_0001, 14'h0001);
        waitChars(c + 30);
        `CHK("ovr clear", 1'b0, pktOverrun)
    endtask

    // Fall inside the load window starts nothing
    task automatic t_load_ignore;
        int c;
        c = rxChars;
        rateSample = 32'h1357_9BDF;
        tempSample = 14'h1357;
        trigIn = 1'b0;
        step(2);
        trigIn = 1'b1;
        step(2);
        fire(32'h0F0F_0F0F, 14'h0F0F);
        waitChars(c + 10);
        step(60);
        `CHK("count", c[15:0] + 16'h000A, rxChars)
        `CHK("first", expPkt(32'h1357_9BDF, 14'h1357), rxPkt)
    endtask

    // Trigger held low through a mid-run reset gives one packet
    task automatic t_reset;
        int c;
        c = rxChars;
        rateSample = 32'hC3A5_5A3C;
        tempSample = 14'h2345;
        trigIn = 1'b0;
        srst = 1'b1;
        step(3);
        srst = 1'b0;
        step(20);
        trigIn = 1'b1;
        waitChars(c + 10);
        `CHK("rst pkt", expPkt(32'hC3A5_5A3C, 14'h2345), rxPkt)
    endtask

    initial begin
        step(6);
        srst = 1'b0;
        step(2);
        t_content();
        t_overrun();
        t_load_ignore();
        t_reset();
        print_verdict();
    end
endmodule
`default_nettype wire
